//--- logic/cfg_decode_pkg.sv
// package for the configuration word decoder: register map, field
// positions, codes, reset values and the carrier structs.
// assumes a 32-bit apb register bus and a single pclk domain.
package cfg_decode_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CONFIG_WORD   = 8'h00;
  localparam logic [7:0] OFF_SYSTEM_CONFIG = 8'h04;
  localparam logic [7:0] OFF_POWER_CONTROL = 8'h08;
  localparam logic [7:0] OFF_DECODE_STATUS = 8'h0c;

  // fields of the configuration word
  localparam int POS_FLASH_SLEEP  = 10;
  localparam int POS_ECC_CONFIG   = 8;
  localparam int POS_RESERVED_ONE = 7;
  localparam int POS_BOOT_ISA     = 6;
  localparam int POS_TRACE_EN     = 5;
  localparam int POS_DEBUG_CHAN   = 3;
  localparam int POS_SCAN_EN      = 2;
  localparam int POS_DEBUGGER     = 0;

  // fields of the system configuration and power control registers
  localparam int POS_RT_ECC_MODE  = 4;
  localparam int POS_RT_SCAN_EN   = 3;
  localparam int POS_REG_STANDBY  = 0;

  // flash ecc configuration codes
  localparam logic [1:0] ECC_OFF_WRITABLE = 2'h3;
  localparam logic [1:0] ECC_OFF_LOCKED   = 2'h2;
  localparam logic [1:0] ECC_DYNAMIC      = 2'h1;
  localparam logic [1:0] ECC_ON           = 2'h0;

  // boot instruction-set field values
  localparam logic [1:0] ISA_FIELD_STANDARD = 2'h2;
  localparam logic [1:0] ISA_FIELD_COMPACT  = 2'h3;

  // debug channel select codes
  localparam logic [1:0] CHAN_PAIR1 = 2'h3;
  localparam logic [1:0] CHAN_PAIR2 = 2'h2;
  localparam logic [1:0] CHAN_PAIR3 = 2'h1;

  // debugger field codes
  localparam logic [1:0] DBG_SCAN_MODULE_OFF = 2'h3;
  localparam logic [1:0] DBG_SCAN_MODULE_ON  = 2'h2;
  localparam logic [1:0] DBG_WIRE_MODULE_OFF = 2'h1;

  // reset values and timing
  localparam logic [31:0] CONFIG_WORD_RESET = 32'h0000_0000;
  localparam logic        REG_STANDBY_RESET = 1'h0;
  localparam logic [1:0]  SETTLE_CYCLES     = 2'h3;
  localparam int          PIN_SYNC_STAGES   = 3;

  // decoded settings handed to the core
  typedef struct packed {
    logic       flash_power_down;
    logic       ecc_enable;
    logic       dynamic_ecc_enable;
    logic       ecc_control_locked;
    logic       word_program_block;
    logic       exception_isa_flag;
    logic [1:0] isa_mode;
    logic       trace_features_enable;
    logic [2:0] pin_pair_enable;
    logic       scan_port_active;
    logic       two_wire_debug_enable;
    logic       incircuit_debug_module;
    logic       reserved_bit_missing;
    logic       config_valid;
  } settings_type;

  typedef enum logic [1:0] {
    PH_SETTLE,
    PH_CAPTURE,
    PH_RUN
  } phase_type;

endpackage

//--- logic/cfg_pin_sync.sv
// multi-stage synchroniser for static levels from the non-volatile array.
// assumes inputs change only around reset; stable marks agreement.
`timescale 1ns/1ns

module cfg_pin_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_out,
  output logic                  stable
);

  // whole state of the chain
  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] stage;
  } sync_state_type;

  sync_state_type sync_q;
  sync_state_type sync_d;

  // refuse a depth that cannot compare the last two stages
  if (STAGES < 3 || WIDTH < 1) begin : g_bad_depth
    $error("cfg_pin_sync needs three stages and one bit");
  end

  // shift chain; first stage feeds only the second
  always_comb
  begin
    sync_d          = sync_q;
    sync_d.stage[0] = level_in;
    for (int i = 1; i < STAGES; i++)
      sync_d.stage[i] = sync_q.stage[i-1];
  end

  // chain register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= '0;
    else
      sync_q <= sync_d;
  end

  // last two stages agree before a value counts
  assign level_out = sync_q.stage[STAGES-1];
  assign stable    = (sync_q.stage[STAGES-1] == sync_q.stage[STAGES-2]);

endmodule

//--- logic/cfg_word_decode.sv
// configuration word decoder with an apb register window.
// assumes the word, code protect and factory scan enable are static
// levels from the non-volatile array, valid around reset release.
//
// Behaviour
// - flash sleep bit set: power down in sleep; else regulator standby.
// - ecc field picks ecc off/dynamic/on and whether runtime bits lock.
// - ecc field 00 blocks single-word flash programming.
// - reset copies the ecc field into system config bits 5:4.
// - boot isa 1 clears exception flag, field 10; 0 sets, field 11.
// - trace bit 5 enables processor trace features.
// - channel select 11/10/01 picks pin pair 1/2/3; 00 reserved.
// - reset copies the scan enable bit into system config bit 3.
// - configured scan enable 0 keeps runtime scan enable at 0.
// - configured scan enable 1 lets software toggle the scan port.
// - debugger field picks scan port or two-wire pins, module on/off.
// - code protection forces the debugger field to 11.
// - factory or user scan enable 0 blocks scan port, not two-wire.
`timescale 1ns/1ns

module cfg_word_decode
  import cfg_decode_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [31:0]           device_configuration_word_zero,
  input  wire logic                  code_protect,
  input  wire logic                  factory_scan_port_enable,
  input  wire logic                  device_sleep,
  output settings_type               core_settings
);

  // whole state of the block
  typedef struct packed {
    phase_type    phase;
    logic [1:0]   settle;
    logic [31:0]  word;
    logic         code_protect;
    logic         factory_scan;
    logic         scan_port_enable;
    logic [1:0]   runtime_ecc_mode_bits;
    logic         regulator_standby_select;
    settings_type settings;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } state_type;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_CONFIG_WORD,
    SEL_SYSTEM_CONFIG,
    SEL_POWER_CONTROL,
    SEL_DECODE_STATUS,
    SEL_NONE
  } reg_sel_type;

  state_type   state_q;
  state_type   state_d;
  logic [33:0] nvm_raw;
  logic [33:0] nvm_sync;
  logic        nvm_stable;

  // the address must reach the highest register
  if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_bad_addr
    $error("cfg_word_decode ADDR_WIDTH must be 4 to 32");
  end

  // address decode, shared by read and write paths
  function automatic reg_sel_type decode_addr(
    input logic [ADDR_WIDTH-1:0] addr
  );
    logic [7:0] low;
    low = 8'(addr);
    if (addr != ADDR_WIDTH'(low))
      return SEL_NONE;
    else if (low == OFF_CONFIG_WORD)
      return SEL_CONFIG_WORD;
    else if (low == OFF_SYSTEM_CONFIG)
      return SEL_SYSTEM_CONFIG;
    else if (low == OFF_POWER_CONTROL)
      return SEL_POWER_CONTROL;
    else if (low == OFF_DECODE_STATUS)
      return SEL_DECODE_STATUS;
    else
      return SEL_NONE;
  endfunction

  // turn captured word and runtime bits into core settings
  function automatic settings_type decode_settings(
    input state_type st,
    input logic      sleep
  );
    settings_type r;
    logic [1:0]   dbg;
    logic [1:0]   ecc_cfg;
    logic [1:0]   chan;
    r       = '0;
    ecc_cfg = st.word[POS_ECC_CONFIG +: 2];
    chan    = st.word[POS_DEBUG_CHAN +: 2];
    dbg     = st.word[POS_DEBUGGER +: 2];
    // protected parts always see the scan-port, module-off code
    if (st.code_protect)
      dbg = DBG_SCAN_MODULE_OFF;
    // sleep power-down either forced or via regulator standby
    r.flash_power_down = sleep & (st.word[POS_FLASH_SLEEP] |
                                  st.regulator_standby_select);
    // ecc on and dynamic follow the runtime copy; lock and word block follow the captured field
    r.ecc_enable         = (st.runtime_ecc_mode_bits == ECC_ON);
    r.dynamic_ecc_enable = (st.runtime_ecc_mode_bits == ECC_DYNAMIC);
    r.ecc_control_locked = (ecc_cfg != ECC_OFF_WRITABLE);
    r.word_program_block = (ecc_cfg == ECC_ON);
    // boot instruction set
    if (st.word[POS_BOOT_ISA])
    begin
      r.exception_isa_flag = 1'h0;
      r.isa_mode           = ISA_FIELD_STANDARD;
    end
    else
    begin
      r.exception_isa_flag = 1'h1;
      r.isa_mode           = ISA_FIELD_COMPACT;
    end
    r.trace_features_enable = st.word[POS_TRACE_EN];
    // one-hot pin pair, none for the reserved code
    case (chan)
      CHAN_PAIR1: r.pin_pair_enable = 3'h1;
      CHAN_PAIR2: r.pin_pair_enable = 3'h2;
      CHAN_PAIR3: r.pin_pair_enable = 3'h4;
      default:    r.pin_pair_enable = 3'h0;
    endcase
    // debugger routing; scan port also needs both enables
    r.incircuit_debug_module = ~dbg[0];
    r.two_wire_debug_enable  = ~dbg[1];
    r.scan_port_active = dbg[1] & st.factory_scan &
                         st.scan_port_enable;
    // a programmed zero in the must-be-one bit is reported
    r.reserved_bit_missing = ~st.word[POS_RESERVED_ONE];
    r.config_valid         = 1'h1;
    return r;
  endfunction

  // word, protect and factory enable come from another domain
  assign nvm_raw = {code_protect, factory_scan_port_enable,
                    device_configuration_word_zero};

  cfg_pin_sync #(
    .WIDTH  (34),
    .STAGES (PIN_SYNC_STAGES)
  ) u_nvm_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .level_in  (nvm_raw),
    .level_out (nvm_sync),
    .stable    (nvm_stable)
  );

  // next-state logic: capture phases, apb access, settings
  always_comb
  begin
    reg_sel_type sel;
    logic        access;
    sel     = decode_addr(paddr);
    access  = psel & penable;
    state_d = state_q;
    state_d.pready  = 1'h0;
    state_d.pslverr = 1'h0;

    // capture once after reset, then hold
    case (state_q.phase)
      PH_SETTLE:
      begin
        if (state_q.settle == SETTLE_CYCLES - 2'h1)
          state_d.phase = PH_CAPTURE;
        else
          state_d.settle = state_q.settle + 2'h1;
      end
      PH_CAPTURE:
      begin
        if (nvm_stable)
        begin
          state_d.word         = nvm_sync[31:0];
          state_d.factory_scan = nvm_sync[32];
          state_d.code_protect = nvm_sync[33];
          state_d.runtime_ecc_mode_bits =
            nvm_sync[POS_ECC_CONFIG +: 2];
          state_d.scan_port_enable = nvm_sync[POS_SCAN_EN];
          state_d.phase = PH_RUN;
        end
      end
      PH_RUN:
      begin
        state_d.phase = PH_RUN;
      end
      default:
      begin
        state_d.phase = PH_SETTLE;
      end
    endcase

    // access phase: answer one cycle later with data and error
    if (access && !state_q.pready)
    begin
      state_d.pready = 1'h1;
      if (sel == SEL_NONE)
        state_d.pslverr = 1'h1;
      if (pwrite)
        state_d.prdata = '0;
      else if (sel == SEL_CONFIG_WORD)
        state_d.prdata = state_q.word;
      else if (sel == SEL_SYSTEM_CONFIG)
      begin
        state_d.prdata = '0;
        state_d.prdata[POS_RT_ECC_MODE +: 2] =
          state_q.runtime_ecc_mode_bits;
        state_d.prdata[POS_RT_SCAN_EN] = state_q.scan_port_enable;
      end
      else if (sel == SEL_POWER_CONTROL)
      begin
        state_d.prdata = '0;
        state_d.prdata[POS_REG_STANDBY] =
          state_q.regulator_standby_select;
      end
      else if (sel == SEL_DECODE_STATUS)
        state_d.prdata = 32'(state_q.settings);
      else
        state_d.prdata = '0;
    end

    // writes land at the completing edge, only once captured
    if (access && state_q.pready && pwrite &&
        state_q.phase == PH_RUN && pstrb[0])
    begin
      if (sel == SEL_SYSTEM_CONFIG)
      begin
        // scan enable writable only if the word allowed it
        if (state_q.word[POS_SCAN_EN])
          state_d.scan_port_enable = pwdata[POS_RT_SCAN_EN];
        else
          state_d.scan_port_enable = 1'h0;
        // ecc bits writable only under the writable code
        if (state_q.word[POS_ECC_CONFIG +: 2] == ECC_OFF_WRITABLE)
          state_d.runtime_ecc_mode_bits =
            pwdata[POS_RT_ECC_MODE +: 2];
      end
      else if (sel == SEL_POWER_CONTROL)
        state_d.regulator_standby_select =
          pwdata[POS_REG_STANDBY];
    end

    // settings stay cleared until the word is captured
    if (state_q.phase == PH_RUN)
      state_d.settings = decode_settings(state_q, device_sleep);
    else
      state_d.settings = '0;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q                          <= '0;
      state_q.phase                    <= PH_SETTLE;
      state_q.word                     <= CONFIG_WORD_RESET;
      state_q.regulator_standby_select <= REG_STANDBY_RESET;
    end
    else
      state_q <= state_d;
  end

  // outputs straight from the state register
  assign prdata        = state_q.prdata;
  assign pready        = state_q.pready;
  assign pslverr       = state_q.pslverr;
  assign core_settings = state_q.settings;

endmodule

//--- verification/cfg_word_decode_props.sv
// checker for the configuration word decoder.
// assumes binding to cfg_word_decode, seeing its ports only.
`timescale 1ns/1ns

module cfg_word_decode_props
  import cfg_decode_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         code_protect,
  input wire logic         device_sleep,
  input wire settings_type core_settings
);
  logic [9:0] fixed;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // settings that only the captured word and code protect feed
  assign fixed = {core_settings.word_program_block,
    core_settings.exception_isa_flag, core_settings.isa_mode,
    core_settings.trace_features_enable, core_settings.pin_pair_enable,
    core_settings.two_wire_debug_enable,
    core_settings.incircuit_debug_module};

  // bus answer timing
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_after_access: assert property
    (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // decoded settings
  a_valid_after_reset: assert property
    ($rose(presetn) |-> ##[1:8] core_settings.config_valid)
    else $error("settings never valid");
  a_settings_hold: assert property
    (core_settings.config_valid &&
    $past(core_settings.config_valid) |-> $stable(fixed))
    else $error("static settings changed");
  a_isa_pair: assert property
    (core_settings.config_valid |->
    core_settings.isa_mode ==
    (core_settings.exception_isa_flag ? 2'h3 : 2'h2))
    else $error("isa field and flag disagree");
  a_pair_single: assert property
    (core_settings.config_valid |->
    $onehot0(core_settings.pin_pair_enable))
    else $error("more than one pin pair");
  a_port_exclusive: assert property
    (core_settings.scan_port_active |->
    !core_settings.two_wire_debug_enable)
    else $error("scan port and two-wire both on");
  a_protect_forces: assert property
    (core_settings.config_valid && code_protect |->
    !core_settings.two_wire_debug_enable &&
    !core_settings.incircuit_debug_module)
    else $error("code protect not forcing debugger");
  a_awake_no_down: assert property
    (core_settings.config_valid &&
    !device_sleep |=> !core_settings.flash_power_down)
    else $error("flash down while awake");
  a_ecc_modes: assert property
    (!(core_settings.ecc_enable &&
    core_settings.dynamic_ecc_enable))
    else $error("two ecc modes at once");
  a_block_locked: assert property
    (core_settings.word_program_block |->
    core_settings.ecc_control_locked)
    else $error("word block without lock");
endmodule

//--- verification/cfg_word_decode_tb.sv
// bench for the configuration word decoder: random words, apb access.
// assumes the package, the design and the checker are compiled first.
`timescale 1ns/1ns

module cfg_word_decode_tb import cfg_decode_pkg::*;;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         code_protect, factory_scan_port_enable, device_sleep;
  logic         cp, fs, sc, sb, sl, er;
  logic [7:0]   paddr;
  logic [3:0]   pstrb;
  logic [1:0]   ec;
  logic [31:0]  pwdata, prdata, word, w, rd, nd;
  settings_type core_settings;
  int           n_fail, n_compared, cyc, seed, i, k;

  cfg_word_decode cfg_word_decode_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .device_configuration_word_zero(word),
    .code_protect(code_protect), .device_sleep(device_sleep),
    .factory_scan_port_enable(factory_scan_port_enable),
    .core_settings(core_settings));

  // 10 mhz clock
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      complete_run;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // pready high ends this wait; if it never comes, only the hang guard does
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected settings from word and runtime state
  function automatic settings_type exp_set();
    settings_type s;
    logic [1:0]   d;
    d = cp ? 2'h3 : w[1:0];
    s = '0;
    s.flash_power_down = sl & (w[10] | sb);
    s.ecc_enable = (ec == ECC_ON);
    s.dynamic_ecc_enable = (ec == ECC_DYNAMIC);
    s.ecc_control_locked = (w[9:8] != ECC_OFF_WRITABLE);
    s.word_program_block = (w[9:8] == ECC_ON);
    s.exception_isa_flag = ~w[6];
    s.isa_mode = w[6] ? 2'h2 : 2'h3;
    s.trace_features_enable = w[5];
    s.pin_pair_enable = {w[4:3] == 2'h1, w[4:3] == 2'h2, w[4:3] == 2'h3};
    s.scan_port_active = d[1] & fs & sc;
    s.two_wire_debug_enable = ~d[1];
    s.incircuit_debug_module = ~d[0];
    s.reserved_bit_missing = ~w[7];
    s.config_valid = 1'b1;
    return s;
  endfunction

  task automatic cmp_set();
    @(posedge pclk);
    @(posedge pclk);
    check(32'(core_settings), 32'(exp_set()));
  endtask

  task complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {presetn, word, code_protect, factory_scan_port_enable} = '0;
    {device_sleep, n_fail, n_compared, cyc} = '0;
    seed = 99691;
    for (i = 0; i < 12; i++)
    begin
      // word with every code of each field across the run
      w = (i == 1) ? 32'h0000_07ff : $random(seed);
      w[9:8] = i[1:0];
      w[4:3] = i[2:1];
      w[1:0] = i[1:0] + i[3:2];
      w[7] = (i != 5);
      cp = (i % 4 == 3);
      fs = (i == 0) ? 1'b1 : 1'($random(seed));
      @(posedge pclk);
      presetn <= 0;
      word <= w;
      code_protect <= cp;
      factory_scan_port_enable <= fs;
      device_sleep <= 0;
      repeat (10) @(posedge pclk);
      presetn <= 1;
      k = 0;
      while (core_settings.config_valid !== 1'b1 && k < 20)
      begin
        @(posedge pclk);
        k++;
      end
      {sc, ec, sb, sl} = {w[2], w[9:8], 2'b00};
      cmp_set();
      apb(1'b0, OFF_CONFIG_WORD, 32'h0, 4'h0);
      check(rd, w);
      apb(1'b0, OFF_SYSTEM_CONFIG, 32'h0, 4'h0);
      check(rd, {26'h0, ec, sc, 3'h0});
      // lane 0 off: inverted write dropped, runtime bits kept
      apb(1'b1, OFF_SYSTEM_CONFIG, ~rd, 4'he);
      apb(1'b0, OFF_SYSTEM_CONFIG, 32'h0, 4'h0);
      check(rd, {26'h0, ec, sc, 3'h0});
      apb(1'b0, OFF_DECODE_STATUS, 32'h0, 4'h0);
      check(rd, 32'(exp_set()));
      nd = $random(seed);
      apb(1'b1, OFF_SYSTEM_CONFIG, nd, 4'hf);
      sc = w[2] & nd[3];
      if (w[9:8] == ECC_OFF_WRITABLE)
        ec = nd[5:4];
      apb(1'b0, OFF_SYSTEM_CONFIG, 32'h0, 4'h0);
      check(rd, {26'h0, ec, sc, 3'h0});
      apb(1'b1, OFF_POWER_CONTROL, nd >> 8, 4'hf);
      sb = nd[8];
      sl = nd[9];
      device_sleep <= sl;
      cmp_set();
      apb(1'b0, OFF_POWER_CONTROL, 32'h0, 4'h0);
      check(rd, {31'h0, sb});
      // unmapped address answers with an error and zero data
      apb(1'b0, 8'h10, 32'h0, 4'h0);
      check(32'(er), 32'h1);
      check(rd, 32'h0);
      // word moves after capture: settings and captured word stay
      word <= ~w;
      repeat (6) @(posedge pclk);
      check(32'(core_settings), 32'(exp_set()));
      apb(1'b0, OFF_CONFIG_WORD, 32'h0, 4'h0);
      check(rd, w);
      $display("test %0d done word %h", i, w);
    end
    complete_run;
  end
endmodule

bind cfg_word_decode cfg_word_decode_props cfg_word_decode_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .code_protect(code_protect),
  .device_sleep(device_sleep), .core_settings(core_settings));
